// *** cmr_channel_map_registers.sv ***
// channel map register bank with its channel sequencer
// assumes one AHB-Lite master, single word transfers, mclk at 50 MHz, rst_b synchronous
`timescale 1ns/1ps
module cmr_channel_map_registers #(
  parameter int NUM_CHAN = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // converter side
  input wire logic convDone,
  output logic seqActive,
  output cmr_pkg::cmr_route_s route
);

  localparam int CHAN_W = $clog2(NUM_CHAN);

  // ************************************************************
  // helper functions
  // ************************************************************

  // true when the byte address hits a channel map register
  function automatic logic isMapped(input logic [31:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    isMapped = (a[31:10] == 22'h000000) && (a[1:0] == 2'h0) && (idx >= cmr_pkg::MAP_BASE_IDX) &&
               (idx < cmr_pkg::MAP_BASE_IDX + 8'(NUM_CHAN));
  endfunction

  // channel slot addressed by a byte address
  function automatic logic [CHAN_W-1:0] slotOf(input logic [31:0] a);
    logic [7:0] d;
    d = a[9:2] - cmr_pkg::MAP_BASE_IDX;
    slotOf = d[CHAN_W-1:0];
  endfunction

  // packs a map entry into its register image; reserved bits read zero
  function automatic logic [15:0] toWord(input cmr_pkg::cmr_chan_map_s m);
    logic [15:0] w;
    w = 16'h0000;
    w[cmr_pkg::EN_BIT] = m.en;
    w[cmr_pkg::SETUP_LSB +: 2] = m.setup;
    w[cmr_pkg::POS_LSB +: 5] = m.pos;
    w[cmr_pkg::NEG_LSB +: 5] = m.neg;
    toWord = w & cmr_pkg::MAP_WRITE_MASK;
  endfunction

  // unpacks a written word; reserved bits are dropped
  function automatic cmr_pkg::cmr_chan_map_s fromWord(input logic [15:0] w);
    cmr_pkg::cmr_chan_map_s m;
    m.en = w[cmr_pkg::EN_BIT];
    m.setup = w[cmr_pkg::SETUP_LSB +: 2];
    m.pos = w[cmr_pkg::POS_LSB +: 5];
    m.neg = w[cmr_pkg::NEG_LSB +: 5];
    fromWord = m;
  endfunction

  // next enabled channel after cur, wrapping round; cur itself comes last
  function automatic logic [CHAN_W-1:0] nextEn(input logic [CHAN_W-1:0] cur, input logic [NUM_CHAN-1:0] en);
    logic [CHAN_W-1:0] c;
    nextEn = cur;
    for (int i = NUM_CHAN; i >= 1; i--) begin
      c = CHAN_W'(int'(cur) + i);
      if (en[c]) begin
        nextEn = c;
      end
    end
  endfunction

  // ************************************************************
  // bus slave and map registers
  // ************************************************************
  cmr_pkg::cmr_chan_map_s mapQ [NUM_CHAN];
  cmr_pkg::cmr_chan_map_s mapD [NUM_CHAN];
  logic wrPendQ, wrPendD;
  logic rdWaitQ, rdWaitD;
  logic rdDoneQ, rdDoneD;
  logic mapHitQ, mapHitD;
  logic [CHAN_W-1:0] slotQ, slotD;
  logic [31:0] rdataQ, rdataD;
  logic accept;
  logic [NUM_CHAN-1:0] enables;

  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = !rdWaitQ; // reads take one wait state, writes none
  assign hresp = 1'b0;
  assign hrdata = rdataQ;

  // enable bits of all channels gathered for the sequencer
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      enables[i] = mapQ[i].en;
    end
  end

  // next state of the bus slave and the register array
  always_comb begin
    mapD = mapQ;
    wrPendD = 1'b0;
    rdWaitD = 1'b0;
    rdDoneD = 1'b0;
    mapHitD = mapHitQ;
    slotD = slotQ;
    rdataD = rdataQ;
    if (wrPendQ && mapHitQ) begin
      mapD[slotQ] = fromWord(hwdata[15:0]);
    end
    if (rdWaitQ) begin
      rdataD = mapHitQ ? {16'h0000, toWord(mapQ[slotQ])} : 32'h00000000;
      rdDoneD = 1'b1;
    end
    if (accept) begin
      mapHitD = isMapped(haddr);
      slotD = slotOf(haddr);
      wrPendD = hwrite;
      rdWaitD = !hwrite;
    end
  end

  // registers of the bus slave and the map array
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        mapQ[i] <= fromWord(cmr_pkg::MAP_RESET);
      end
      wrPendQ <= 1'b0;
      rdWaitQ <= 1'b0;
      rdDoneQ <= 1'b0;
      mapHitQ <= 1'b0;
      slotQ <= '0;
      rdataQ <= 32'h00000000;
    end else begin
      mapQ <= mapD;
      wrPendQ <= wrPendD;
      rdWaitQ <= rdWaitD;
      rdDoneQ <= rdDoneD;
      mapHitQ <= mapHitD;
      slotQ <= slotD;
      rdataQ <= rdataD;
    end
  end

  // ************************************************************
  // channel sequencer
  // ************************************************************
  cmr_pkg::cmr_seq_e seqQ, seqD;
  logic [CHAN_W-1:0] chanQ, chanD;

  // steps to the next enabled channel after each conversion
  always_comb begin
    seqD = seqQ;
    chanD = chanQ;
    case (seqQ)
      cmr_pkg::SEQ_IDLE: begin
        if (|enables) begin
          seqD = cmr_pkg::SEQ_RUN;
          chanD = nextEn({CHAN_W{1'b1}}, enables); // lowest enabled channel first
        end
      end
      cmr_pkg::SEQ_RUN: begin
        if (!(|enables)) begin
          seqD = cmr_pkg::SEQ_IDLE;
        end else if (convDone || !enables[chanQ]) begin
          chanD = nextEn(chanQ, enables);
        end
      end
      default: begin
        seqD = cmr_pkg::SEQ_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      seqQ <= cmr_pkg::SEQ_IDLE;
      chanQ <= '0;
    end else begin
      seqQ <= seqD;
      chanQ <= chanD;
    end
  end

  // routing of the converting channel, straight from its map flip-flops
  assign seqActive = (seqQ == cmr_pkg::SEQ_RUN);
  assign route.chan = 2'(chanQ);
  assign route.setup = mapQ[chanQ].setup;
  assign route.pos = mapQ[chanQ].pos;
  assign route.neg = mapQ[chanQ].neg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // number of enabled channels, for the sequencer checks
  int enCount;
  always_comb begin
    enCount = 0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      enCount = enCount + int'(enables[i]);
    end
  end

  // read address phase taken by the slave
  sequence readAddr;
    accept && !hwrite;
  endsequence

  // one wait cycle, then ready with the loaded word
  sequence readData;
    !hreadyout ##1 (hreadyout && rdDoneQ);
  endsequence

  // packed image of every map word, so whole-bank stability can be checked
  logic [NUM_CHAN*16-1:0] mapImage;
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      mapImage[i*16 +: 16] = toWord(mapQ[i]);
    end
  end

  // data phase that lands a word in a mapped slot
  sequence mappedWrite;
    wrPendQ && mapHitQ;
  endsequence

  // data phase rewriting the enabled channel now routed, with no conversion end to move it on
  sequence routedRewrite;
    seqActive && wrPendQ && mapHitQ && (slotQ == chanQ) && enables[chanQ] &&
      hwdata[cmr_pkg::EN_BIT] && !convDone;
  endsequence

  // bus slave: wait states and the read image
  a_read_one_wait: assert property (readAddr |=> readData) else $error("read answer not after one wait");
  a_write_no_wait: assert property (accept && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_rsvd_read_zero: assert property (rdDoneQ |-> (hrdata[cmr_pkg::RSVD_BIT] == 1'b0) && (hrdata[11:10] == 2'h0))
    else $error("reserved bits read nonzero");
  a_upper_half_zero: assert property (rdDoneQ |-> hrdata[31:16] == 16'h0000) else $error("upper half not zero");
  a_read_unmapped_zero: assert property (rdWaitQ && !mapHitQ |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_read_value: assert property (rdWaitQ && mapHitQ && !wrPendQ |=>
      hrdata[15:0] == mapImage[16*$past(slotQ) +: 16])
    else $error("read data differs from map word");

  // map array: reset image, masked writes, no other change
  a_map_two_reset: assert property ($past(rst_b) == 1'b0 |-> toWord(mapQ[2]) == cmr_pkg::MAP_RESET)
    else $error("map two reset value wrong");
  a_reset_state: assert property ($past(rst_b) == 1'b0 |->
      !seqActive && (route.chan == 2'h0) && (mapImage == {NUM_CHAN{cmr_pkg::MAP_RESET}}))
    else $error("state after reset wrong");
  a_write_lands: assert property (mappedWrite |=>
      mapImage[16*$past(slotQ) +: 16] == ($past(hwdata[15:0]) & cmr_pkg::MAP_WRITE_MASK))
    else $error("written word not held");
  a_unmapped_ignored: assert property (wrPendQ && !mapHitQ |=> $stable(mapImage))
    else $error("unmapped write changed a map");
  a_map_hold: assert property (!wrPendQ |=> $stable(mapImage))
    else $error("map changed without a write");
  a_enable_write: assert property (accept && hwrite && haddr == {22'h000000, cmr_pkg::CHAN_TWO_MAP_IDX, 2'h0}
      ##1 hreadyout |=> mapQ[2].en == $past(hwdata[cmr_pkg::EN_BIT]))
    else $error("channel two enable not written");

  // sequencer: start, stop, stepping and holding a lone channel
  a_seq_start: assert property (!seqActive && (|enables) && !wrPendQ |=> seqActive && enables[chanQ])
    else $error("sequencer did not start");
  a_seq_stop: assert property (seqActive && !(|enables) |=> !seqActive)
    else $error("sequencer did not stop");
  a_seq_advance: assert property (seqActive && convDone && enCount > 1 && !wrPendQ |=>
      chanQ != $past(chanQ) && enables[chanQ])
    else $error("sequencer did not advance");
  a_seq_single_hold: assert property (seqActive && enCount == 1 && enables[chanQ] && !wrPendQ |=>
      $stable(chanQ))
    else $error("lone channel not held");

  // routing follows a rewrite of the converting channel in the next cycle
  a_neg_route: assert property (routedRewrite |=> route.neg == $past(hwdata[4:0]))
    else $error("negative route wrong");
  a_pos_route: assert property (routedRewrite |=> route.pos == $past(hwdata[9:5]))
    else $error("positive route wrong");
  a_setup_route: assert property (routedRewrite |=> route.setup == $past(hwdata[13:12]))
    else $error("setup route wrong");

endmodule

// *** cmr_channel_map_registers_tb.sv ***
// self-checking testbench for the channel map register bank
// assumes the bank answers as an AHB-Lite slave with hready tied back to hreadyout
`timescale 1ns/1ps
module cmr_channel_map_registers_tb;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic convDone = 1'b0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic seqActive;
  cmr_pkg::cmr_route_s route;
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic [15:0] d;
  logic [4:0] codes [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h15, 5'h16};

  // 50 MHz clock
  always #10 mclk = ~mclk;

  cmr_channel_map_registers uut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .convDone(convDone), .seqActive(seqActive), .route(route));

  // ************************************************************
  // bus and check tasks
  // ************************************************************
  // compare and count, report at once on mismatch
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // hold the current phase until hready is seen high at a rising edge
  task automatic wait_ready();
    @(negedge mclk);
    while (hreadyout !== 1'b1) @(negedge mclk);
    rd = hrdata;
    @(posedge mclk);
  endtask

  // one single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    if (!wr) chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // read a word and compare it
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk("read data", exp, rd);
  endtask

  // one conversion finished, then compare the channel now routed
  task automatic done_chk(input logic [1:0] ch);
    @(posedge mclk);
    convDone <= 1'b1;
    @(posedge mclk);
    convDone <= 1'b0;
    @(negedge mclk);
    chk("route chan", {30'h0, ch}, {30'h0, route.chan});
  endtask

  // closing verdict
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk("seqActive idle", 32'h0, {31'h0, seqActive});
    chk("route after reset", 32'h0001, {18'h0, route});
    // a conversion end while idle is ignored
    done_chk(2'd0);
    chk("seqActive after done", 32'h0, {31'h0, seqActive});
    for (int a = 0; a < 4; a++) rd_chk(32'h40 + 4 * a, 32'h0001);
    rd_chk(32'h48, 32'h0001);
    // unmapped places read zero and ignore writes
    xfer(1'b1, 32'h54, 32'hffff);
    rd_chk(32'h54, 32'h0);
    rd_chk(32'h3c, 32'h0);
    // reserved bits 11 and 10 stay zero; bit 14 is always written as zero
    xfer(1'b1, 32'h48, 32'hbfff);
    rd_chk(32'h48, 32'hb3ff);
    // every input code and setup code on a lone enabled channel
    for (int i = 0; i < 7; i++) begin
      d = {1'b1, 1'b0, i[1:0], 2'b00, codes[i], codes[6 - i]};
      xfer(1'b1, 32'h48, {16'h0, d});
      rd_chk(32'h48, {16'h0, d});
      repeat (2) @(negedge mclk);
      chk("route chan", 32'h2, {30'h0, route.chan});
      chk("route setup", {30'h0, i[1:0]}, {30'h0, route.setup});
      chk("route pos", {27'h0, codes[i]}, {27'h0, route.pos});
      chk("route neg", {27'h0, codes[6 - i]}, {27'h0, route.neg});
    end
    chk("seqActive run", 32'h1, {31'h0, seqActive});
    // a lone enabled channel stays put after a conversion end
    done_chk(2'd2);
    // several enabled channels are stepped through upward with wrap
    xfer(1'b1, 32'h44, 32'h9000);
    done_chk(2'd1);
    chk("route setup ch1", 32'h1, {30'h0, route.setup});
    done_chk(2'd2);
    xfer(1'b1, 32'h4c, 32'h8000);
    done_chk(2'd3);
    done_chk(2'd1);
    // disabling every channel stops the sequencer
    for (int a = 1; a < 4; a++) xfer(1'b1, 32'h40 + 4 * a, 32'h0);
    repeat (2) @(negedge mclk);
    chk("seqActive stop", 32'h0, {31'h0, seqActive});
    // a reset in mid-run brings channel two's map back to its reset value
    xfer(1'b1, 32'h48, 32'h8fff);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk("seqActive reset", 32'h0, {31'h0, seqActive});
    rd_chk(32'h48, 32'h0001);
    print_verdict();
  end
endmodule

// *** cmr_pkg.sv ***
// package for the channel map register bank: register indices, field layout,
// reset values and the sequencer state codes
// assumes a 32-bit AHB-Lite register bus; registers sit at byte address 4 * index
package cmr_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] MAP_BASE_IDX = 8'h10; // index of the first channel map register
  localparam logic [7:0] CHAN_TWO_MAP_IDX = 8'h12; // index of channel_two_map
  localparam logic [15:0] MAP_RESET = 16'h0001; // value of every map register after reset
  localparam logic [15:0] MAP_WRITE_MASK = 16'hb3ff; // bits 14, 11 and 10 are reserved

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int EN_BIT = 15;
  localparam int RSVD_BIT = 14;
  localparam int SETUP_LSB = 12;
  localparam int POS_LSB = 5;
  localparam int NEG_LSB = 0;

  // ************************************************************
  // input selector codes
  // ************************************************************
  localparam logic [4:0] SEL_AIN0 = 5'h00;
  localparam logic [4:0] SEL_AIN4 = 5'h04;
  localparam logic [4:0] SEL_REF_POS = 5'h15;
  localparam logic [4:0] SEL_REF_NEG = 5'h16;

  // one channel map entry as held in flip-flops
  typedef struct packed {
    logic en;
    logic [1:0] setup;
    logic [4:0] pos;
    logic [4:0] neg;
  } cmr_chan_map_s;

  // routing presented to the converter for the channel now converting
  typedef struct packed {
    logic [1:0] chan;
    logic [1:0] setup;
    logic [4:0] pos;
    logic [4:0] neg;
  } cmr_route_s;

  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_RUN = 2'b10
  } cmr_seq_e;

endpackage
